//--- desc_dma_pkg.sv
`default_nettype none
package desc_dma_pkg;

    // Descriptor geometry in external memory
    localparam logic [31:0] DESC_STRIDE   = 32'h0000_0008;
    localparam logic [31:0] PTR_OFFSET    = 32'h0000_0004;
    localparam logic [31:0] RESET_PTR     = 32'h0000_0000;

    // Status halfword sits in the upper half of the first word
    localparam int unsigned STATUS_LSB    = 16;

    // Bit positions inside the status halfword
    localparam int unsigned OWN_BIT       = 15;
    localparam int unsigned SOFT_A_BIT    = 14;
    localparam int unsigned WRAP_BIT      = 13;
    localparam int unsigned SOFT_B_BIT    = 12;
    localparam int unsigned LAST_BIT      = 11;
    localparam int unsigned APPEND_BIT    = 10;
    localparam int unsigned CORRUPT_BIT   = 9;
    localparam int unsigned MISS_BIT      = 8;
    localparam int unsigned BCAST_BIT     = 7;
    localparam int unsigned MCAST_BIT     = 6;
    localparam int unsigned LENV_BIT      = 5;
    localparam int unsigned NONOCT_BIT    = 4;
    localparam int unsigned CRC_BIT       = 2;
    localparam int unsigned OVR_BIT       = 1;
    localparam int unsigned TRUNC_BIT     = 0;

    // Field masks
    localparam logic [15:0] FRAME_STAT_MASK = 16'h01f7;
    localparam logic [15:0] RX_SIZE_MASK    = 16'h07f0;
    localparam logic [15:0] TX_LEN_MASK     = 16'hffe0;

    // Ring channel states
    typedef enum logic [1:0] {CH_STOP, CH_FETCH, CH_HOLD, CH_CLOSE}
        ch_state_t;

    // Memory bus states
    typedef enum logic [1:0] {B_IDLE, B_RD0, B_RD1, B_WR} bus_state_t;

    // Receive buffer close report from the receive path
    typedef struct packed {
        logic        last;
        logic [15:0] frame_len;
        logic        miss;
        logic        broadcast_hit_flag;
        logic        multicast_hit_flag;
        logic        length_violation_flag;
        logic        non_octet;
        logic        checksum_error_flag;
        logic        fifo_lost_data_flag;
        logic        cut_short_flag;
    } rx_close_t;

    // Transmit buffer handed to the transmit path
    typedef struct packed {
        logic [31:0] addr;
        logic [15:0] len;
        logic        last;
        logic        append_checksum_flag;
        logic        corrupt_checksum_flag;
    } tx_buf_t;

endpackage
`default_nettype wire

//--- desc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module desc_mem_model
(
    // Clock
    input  wire logic        clk,
    // Memory bus from the engine
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    output logic      [31:0] mem_rdata,
    output logic             mem_ack,
    // Wait states per bus cycle
    input  wire logic [1:0]  slow
);
    // Word store, last read address, wait counter
    logic [31:0] mem [0:255];
    logic [31:0] last_rd = 32'h0;
    logic [1:0]  wait_q  = 2'h0;
    initial mem_ack = 1'b0;
    initial mem_rdata = 32'h0;
    // Answer after the wait states; data scrambles outside the ack
    always @(posedge clk)
    begin
        mem_ack   <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack && wait_q == slow)
        begin
            wait_q    <= 2'h0;
            mem_ack   <= 1'b1;
            mem_rdata <= mem[mem_addr[9:2]];
            if (mem_we)
                mem[mem_addr[9:2]] <= mem_wdata;
            else
                last_rd <= mem_addr;
        end
        else if (mem_req && !mem_ack)
            wait_q <= wait_q + 2'h1;
    end
endmodule
`default_nettype wire

//--- ethernet_buffer_descriptor_dma.sv
// How it works
// RULE_01 - Empty flag cleared when receive buffer closes
// RULE_02 - Software bits never changed, never consulted
// RULE_03 - Receive wrap bit selects ring start
// RULE_04 - Last bit set only on frame end
// RULE_05 - Frame status written only on last
// RULE_06 - Miss bit when accepted only by accept-all
// RULE_07 - Broadcast and multicast destination flags
// RULE_08 - Length violation above programmed maximum
// RULE_09 - Non-octet frames keep checksum bit clear
// RULE_10 - Checksum error for whole-octet frames
// RULE_11 - Overrun zeroes miss, length, non-octet, checksum
// RULE_12 - Truncation flag for oversize frames
// RULE_13 - Length halfword: buffer size or frame
// RULE_14 - Receive pointer passed on, never written
// RULE_15 - Software pokes receive active after handover
// RULE_16 - Ready flag cleared after transmit buffer done
// RULE_17 - Transmit wrap bit selects ring start
// RULE_18 - Last and append-checksum passed to transmitter
// RULE_19 - Corrupt checksum flag passed to transmitter
// RULE_20 - Transmit length low five bits ignored
// RULE_21 - Transmit pointer passed on, never written
// RULE_22 - Software pokes transmit active after setup
// RULE_23 - Poll twice, then stop until poked
// RULE_24 - Advance eight bytes without wrap
`timescale 1ns/1ps
`default_nettype none
module ethernet_buffer_descriptor_dma
(
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          resetn,
    // Configuration and control
    input  wire logic                          enable,
    input  wire logic                   [31:0] rx_ring_start,
    input  wire logic                   [31:0] tx_ring_start,
    input  wire logic                   [15:0] rx_buffer_size,
    input  wire logic                          accept_all_select,
    input  wire logic                          rx_descriptor_active,
    input  wire logic                          tx_descriptor_active,
    // Ring status
    output logic                               rx_stopped,
    output logic                               tx_stopped,
    // Memory master
    output logic                               mem_req,
    output logic                               mem_we,
    output logic                        [31:0] mem_addr,
    output logic                        [31:0] mem_wdata,
    input  wire logic                   [31:0] mem_rdata,
    input  wire logic                          mem_ack,
    // Receive path
    output logic                               rx_buf_valid,
    output logic                        [31:0] rx_buf_addr,
    input  wire logic                          rx_close_valid,
    input  wire desc_dma_pkg::rx_close_t       rx_close,
    // Transmit path
    output logic                               tx_buf_valid,
    output desc_dma_pkg::tx_buf_t              tx_buf,
    input  wire logic                          tx_buf_done
);

    // Channel index 0 is receive, 1 is transmit
    desc_dma_pkg::ch_state_t  ch_q [2];
    desc_dma_pkg::ch_state_t  ch_d [2];
    desc_dma_pkg::bus_state_t bus_q;
    desc_dma_pkg::bus_state_t bus_d;
    logic                     own_q;     // Channel owning the bus
    logic                     own_d;
    logic [1:0][31:0]         ptr_q;     // Current descriptor address
    logic [1:0][31:0]         ptr_d;
    logic [1:0][31:0]         word0_q;   // Fetched first word
    logic [1:0][31:0]         word0_d;
    logic [1:0][31:0]         bufp_q;    // Fetched buffer pointer
    logic [1:0][31:0]         bufp_d;
    logic [1:0]               retry_q;   // One failed poll seen
    logic [1:0]               retry_d;
    logic [1:0]               pend_q;    // Active poke pending
    logic [1:0]               pend_d;
    logic [31:0]              addr_q;
    logic [31:0]              addr_d;
    logic                     we_q;
    logic                     we_d;
    logic [31:0]              wdata_q;
    logic [31:0]              wdata_d;
    desc_dma_pkg::rx_close_t  close_q;   // Captured close report
    desc_dma_pkg::rx_close_t  close_d;
    logic [1:0][31:0]         ring;      // Ring start per channel
    logic [15:0]              rx_status; // Composed receive status
    logic [15:0]              rx_len;    // Receive length halfword
    logic [31:0]              rx_wb;     // Receive write-back word
    logic [31:0]              tx_wb;     // Transmit write-back word
    logic                     sel;       // Channel picked when idle
    logic                     any_work;

    // Picks whether a channel needs the bus
    function automatic logic wants_bus(desc_dma_pkg::ch_state_t s);
        wants_bus = (s == desc_dma_pkg::CH_FETCH) ||
                    (s == desc_dma_pkg::CH_CLOSE);
    endfunction

    assign ring[0] = rx_ring_start;
    assign ring[1] = tx_ring_start;

    // Receive status composer
    rx_status_compose u_compose
    (
        .old_status        (word0_q[0][31:16]),
        .close             (close_q),
        .accept_all_select (accept_all_select),
        .new_status        (rx_status)
    );

    // Write-back words
    always_comb
    begin
        // RULE_13 - size or frame length
        rx_len = close_q.last ? close_q.frame_len
                              : (rx_buffer_size & desc_dma_pkg::RX_SIZE_MASK);
        rx_wb = {rx_status, rx_len};
        // RULE_16 - clear ready, keep rest
        tx_wb = word0_q[1];
        tx_wb[desc_dma_pkg::STATUS_LSB + desc_dma_pkg::OWN_BIT] = 1'b0;
    end

    // Receive gets the bus first
    assign sel      = wants_bus(ch_q[0]) ? 1'b0 : 1'b1;
    assign any_work = wants_bus(ch_q[0]) || wants_bus(ch_q[1]);

    // Next state for rings and bus
    always_comb
    begin
        bus_d   = bus_q;
        own_d   = own_q;
        ch_d    = ch_q;
        ptr_d   = ptr_q;
        word0_d = word0_q;
        bufp_d  = bufp_q;
        retry_d = retry_q;
        addr_d  = addr_q;
        we_d    = we_q;
        wdata_d = wdata_q;
        close_d = close_q;
        // Pokes are sticky until they restart a stopped ring or enable drops
        pend_d  = pend_q | {tx_descriptor_active, rx_descriptor_active};
        for (int i = 0; i < 2; i++)
        begin
            // Restart a stopped ring
            if (ch_q[i] == desc_dma_pkg::CH_STOP && pend_d[i])
            begin
                ch_d[i]    = desc_dma_pkg::CH_FETCH;
                pend_d[i]  = 1'b0;
                retry_d[i] = 1'b0;
            end
        end
        // Receive buffer closed by the receive path
        if (ch_q[0] == desc_dma_pkg::CH_HOLD && rx_close_valid)
        begin
            close_d = rx_close;
            ch_d[0] = desc_dma_pkg::CH_CLOSE;
        end
        // Transmit buffer finished
        if (ch_q[1] == desc_dma_pkg::CH_HOLD && tx_buf_done)
        begin
            ch_d[1] = desc_dma_pkg::CH_CLOSE;
        end
        case (bus_q)
            desc_dma_pkg::B_IDLE:
            begin
                // Start a fetch or a write-back
                if (any_work)
                begin
                    own_d  = sel;
                    addr_d = ptr_q[sel];
                    if (ch_q[sel] == desc_dma_pkg::CH_FETCH)
                    begin
                        we_d  = 1'b0;
                        bus_d = desc_dma_pkg::B_RD0;
                    end
                    else
                    begin
                        we_d    = 1'b1;
                        wdata_d = sel ? tx_wb : rx_wb;
                        bus_d   = desc_dma_pkg::B_WR;
                    end
                end
            end
            desc_dma_pkg::B_RD0:
            begin
                // First word: check ownership
                if (mem_ack)
                begin
                    word0_d[own_q] = mem_rdata;
                    bus_d = desc_dma_pkg::B_IDLE;
                    if (mem_rdata[desc_dma_pkg::STATUS_LSB +
                                  desc_dma_pkg::OWN_BIT])
                    begin
                        addr_d         = addr_q + desc_dma_pkg::PTR_OFFSET;
                        retry_d[own_q] = 1'b0;
                        bus_d          = desc_dma_pkg::B_RD1;
                    end
                    // RULE_23 - second miss stops ring
                    else if (retry_q[own_q])
                    begin
                        ch_d[own_q]    = desc_dma_pkg::CH_STOP;
                        retry_d[own_q] = 1'b0;
                    end
                    else
                    begin
                        retry_d[own_q] = 1'b1;
                    end
                end
            end
            desc_dma_pkg::B_RD1:
            begin
                // RULE_14 - pointer read only
                if (mem_ack)
                begin
                    bufp_d[own_q] = mem_rdata;
                    ch_d[own_q]   = desc_dma_pkg::CH_HOLD;
                    bus_d         = desc_dma_pkg::B_IDLE;
                end
            end
            desc_dma_pkg::B_WR:
            begin
                // Write-back done: move to next descriptor
                if (mem_ack)
                begin
                    // RULE_03 - wrap to ring start
                    // RULE_17 - wrap to ring start
                    if (word0_q[own_q][desc_dma_pkg::STATUS_LSB +
                                       desc_dma_pkg::WRAP_BIT])
                    begin
                        ptr_d[own_q] = ring[own_q];
                    end
                    // RULE_24 - step one descriptor
                    else
                    begin
                        ptr_d[own_q] = ptr_q[own_q] +
                                       desc_dma_pkg::DESC_STRIDE;
                    end
                    ch_d[own_q] = desc_dma_pkg::CH_FETCH;
                    we_d        = 1'b0;
                    bus_d       = desc_dma_pkg::B_IDLE;
                end
            end
            default:
            begin
                bus_d = desc_dma_pkg::B_IDLE;
            end
        endcase
        // Disabled: terminate activity, reload pointers
        if (!enable)
        begin
            bus_d   = desc_dma_pkg::B_IDLE;
            ch_d[0] = desc_dma_pkg::CH_STOP;
            ch_d[1] = desc_dma_pkg::CH_STOP;
            ptr_d   = ring;
            pend_d  = 2'b00;
            retry_d = 2'b00;
            we_d    = 1'b0;
        end
    end

    // Registers
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bus_q   <= desc_dma_pkg::B_IDLE;
            own_q   <= 1'b0;
            ch_q[0] <= desc_dma_pkg::CH_STOP;
            ch_q[1] <= desc_dma_pkg::CH_STOP;
            ptr_q   <= {2{desc_dma_pkg::RESET_PTR}};
            word0_q <= '0;
            bufp_q  <= '0;
            retry_q <= 2'b00;
            pend_q  <= 2'b00;
            addr_q  <= 32'h0000_0000;
            we_q    <= 1'b0;
            wdata_q <= 32'h0000_0000;
            close_q <= '0;
        end
        else
        begin
            bus_q   <= bus_d;
            own_q   <= own_d;
            ch_q    <= ch_d;
            ptr_q   <= ptr_d;
            word0_q <= word0_d;
            bufp_q  <= bufp_d;
            retry_q <= retry_d;
            pend_q  <= pend_d;
            addr_q  <= addr_d;
            we_q    <= we_d;
            wdata_q <= wdata_d;
            close_q <= close_d;
        end
    end

    // Outputs
    assign mem_req      = (bus_q != desc_dma_pkg::B_IDLE);
    assign mem_we       = we_q;
    assign mem_addr     = addr_q;
    assign mem_wdata    = wdata_q;
    assign rx_stopped   = (ch_q[0] == desc_dma_pkg::CH_STOP);
    assign tx_stopped   = (ch_q[1] == desc_dma_pkg::CH_STOP);
    assign rx_buf_valid = (ch_q[0] == desc_dma_pkg::CH_HOLD);
    assign rx_buf_addr  = bufp_q[0];
    assign tx_buf_valid = (ch_q[1] == desc_dma_pkg::CH_HOLD);

    // Transmit buffer fields
    always_comb
    begin
        // RULE_21 - pointer passed, never written
        tx_buf.addr = bufp_q[1];
        // RULE_20 - low length bits dropped
        tx_buf.len  = word0_q[1][15:0] & desc_dma_pkg::TX_LEN_MASK;
        // RULE_18 - last and append flags
        tx_buf.last = word0_q[1][desc_dma_pkg::STATUS_LSB +
                                 desc_dma_pkg::LAST_BIT];
        tx_buf.append_checksum_flag =
            word0_q[1][desc_dma_pkg::STATUS_LSB + desc_dma_pkg::APPEND_BIT];
        // RULE_19 - corrupt checksum flag
        tx_buf.corrupt_checksum_flag =
            word0_q[1][desc_dma_pkg::STATUS_LSB + desc_dma_pkg::CORRUPT_BIT];
    end

    // Checks
    logic wr_rx;
    logic wr_tx;
    assign wr_rx = mem_req && mem_we && !own_q;
    assign wr_tx = mem_req && mem_we && own_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // RULE_01 - empty flag cleared
    rx_own_clear_a: assert property (wr_rx |-> !mem_wdata[31]) // RULE_01
        else $error("rx write-back leaves empty flag set");
    // RULE_02 - software bits kept
    soft_bits_kept_a: assert property ( // RULE_02
        mem_req && mem_we |-> mem_wdata[30] == word0_q[own_q][30] &&
                              mem_wdata[28] == word0_q[own_q][28])
        else $error("software bits altered");
    // RULE_03 - wrap reload
    wrap_reload_a: assert property ( // RULE_03
        wr_rx && mem_ack && word0_q[0][29] && enable
        |=> ptr_q[0] == $past(rx_ring_start))
        else $error("rx wrap did not reload ring start");
    // RULE_05 - non-last status untouched
    nonlast_status_a: assert property ( // RULE_05
        wr_rx && !close_q.last |-> ((mem_wdata[31:16] ^ word0_q[0][31:16])
                                    & desc_dma_pkg::FRAME_STAT_MASK) == 0)
        else $error("status changed in non-last descriptor");
    // RULE_09 - non-octet hides checksum
    nonoct_crc_a: assert property ( // RULE_09
        wr_rx && mem_wdata[20] |-> !mem_wdata[18])
        else $error("checksum bit set with non-octet bit");
    // RULE_11 - overrun zeroes bits
    overrun_zero_a: assert property ( // RULE_11
        wr_rx && mem_wdata[17] |-> mem_wdata[24] == 0 && mem_wdata[21] == 0
                                && mem_wdata[20] == 0 && mem_wdata[18] == 0)
        else $error("overrun left error bits set");
    // RULE_13 - non-last length is buffer size
    rx_len_size_a: assert property ( // RULE_13
        wr_rx && !mem_wdata[27] |-> mem_wdata[15:0] ==
            (rx_buffer_size & desc_dma_pkg::RX_SIZE_MASK))
        else $error("non-last length not buffer size");
    // RULE_14 - writes hit only the first word
    first_word_a: assert property ( // RULE_14
        mem_req && mem_we |-> mem_addr == ptr_q[own_q])
        else $error("write outside first descriptor word");
    // RULE_16 - ready flag cleared
    tx_ready_clear_a: assert property ( // RULE_16
        wr_tx |-> !mem_wdata[31] && mem_wdata[15:0] == word0_q[1][15:0])
        else $error("tx write-back wrong");
    // RULE_23 - second miss stops
    poll_stop_a: assert property ( // RULE_23
        bus_q == desc_dma_pkg::B_RD0 && mem_ack && !mem_rdata[31] &&
        retry_q[own_q] && !own_q && enable ##1 !rx_descriptor_active
        |-> rx_stopped)
        else $error("ring did not stop after second miss");
    // RULE_24 - step of eight
    step_eight_a: assert property ( // RULE_24
        wr_rx && mem_ack && !word0_q[0][29] && enable
        |=> ptr_q[0] == $past(ptr_q[0]) + 32'h0000_0008)
        else $error("rx pointer did not advance by one descriptor");
    // Bus request held until acknowledged
    req_hold_a: assert property (
        mem_req && !mem_ack && enable |=> mem_req && $stable(mem_addr))
        else $error("request dropped before acknowledge");

    rx_last_c: cover property (wr_rx && mem_ack && close_q.last);
    tx_done_c: cover property (wr_tx && mem_ack);
    stop_c:    cover property (!rx_stopped ##1 rx_stopped);
    wrap_c:    cover property (wr_tx && mem_ack && word0_q[1][29]);

endmodule
`default_nettype wire

//--- rx_status_compose.sv
`timescale 1ns/1ps
`default_nettype none
module rx_status_compose
(
    // Status halfword as fetched
    input  wire logic                   [15:0] old_status,
    // Close report and mode
    input  wire desc_dma_pkg::rx_close_t       close,
    input  wire logic                          accept_all_select,
    // Status halfword to write back
    output logic                        [15:0] new_status
);

    // Overrun forces the miss, length, non-octet and checksum bits to zero
    logic ovr;
    assign ovr = close.fifo_lost_data_flag;

    // Compose the closing status halfword
    always_comb
    begin
        new_status = old_status;
        // RULE_01 - hand buffer back
        new_status[desc_dma_pkg::OWN_BIT] = 1'b0;
        // RULE_04 - last marker written
        new_status[desc_dma_pkg::LAST_BIT] = close.last;
        // RULE_05 - status only on last
        if (close.last)
        begin
            new_status = new_status & ~desc_dma_pkg::FRAME_STAT_MASK;
            // RULE_06 - miss under accept-all
            new_status[desc_dma_pkg::MISS_BIT] =
                accept_all_select & close.miss & ~ovr;
            // RULE_07 - broadcast and multicast
            new_status[desc_dma_pkg::BCAST_BIT] = close.broadcast_hit_flag;
            new_status[desc_dma_pkg::MCAST_BIT] =
                close.multicast_hit_flag & ~close.broadcast_hit_flag;
            // RULE_08 - length violation
            new_status[desc_dma_pkg::LENV_BIT] =
                close.length_violation_flag & ~ovr;
            // RULE_09 - non-octet hides checksum
            new_status[desc_dma_pkg::NONOCT_BIT] = close.non_octet & ~ovr;
            // RULE_10 - checksum error
            new_status[desc_dma_pkg::CRC_BIT] =
                close.checksum_error_flag & ~close.non_octet & ~ovr;
            // RULE_11 - overrun flag
            new_status[desc_dma_pkg::OVR_BIT] = ovr;
            // RULE_12 - truncation flag
            new_status[desc_dma_pkg::TRUNC_BIT] = close.cut_short_flag;
        end
    end

endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // Clock, reset and control inputs
    logic        clk     = 1'b0;
    logic        resetn  = 1'b0;
    logic        enable  = 1'b0;
    logic        rx_poke = 1'b0;
    logic        tx_poke = 1'b0;
    logic        close_v = 1'b0;
    logic        done_v  = 1'b0;
    logic [1:0]  slow    = 2'h0;
    logic        accept  = 1'b1;
    desc_dma_pkg::rx_close_t close = '0;
    // Engine outputs and memory bus
    logic        rx_stopped, tx_stopped, mem_req, mem_we, mem_ack;
    logic        rx_buf_valid, tx_buf_valid;
    logic [31:0] mem_addr, mem_wdata, mem_rdata, rx_buf_addr;
    desc_dma_pkg::tx_buf_t tx_buf;
    int          error_cnt   = 0;
    int          checks_done = 0;

    always #5 clk = ~clk;

    ethernet_buffer_descriptor_dma i_dut (
        .clk(clk), .resetn(resetn), .enable(enable),
        .rx_ring_start(32'h0000_0100), .tx_ring_start(32'h0000_0200),
        .rx_buffer_size(16'h0123), .accept_all_select(accept),
        .rx_descriptor_active(rx_poke), .tx_descriptor_active(tx_poke),
        .rx_stopped(rx_stopped), .tx_stopped(tx_stopped),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
        .rx_buf_valid(rx_buf_valid), .rx_buf_addr(rx_buf_addr),
        .rx_close_valid(close_v), .rx_close(close),
        .tx_buf_valid(tx_buf_valid), .tx_buf(tx_buf),
        .tx_buf_done(done_v));

    desc_mem_model i_mem (
        .clk(clk), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .slow(slow));

    // Count one comparison, report a mismatch
    task automatic check32(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Counts, verdict, stop
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Bounded wait: 0 rx held, 1 rx stopped, 2 tx held, 3 tx stopped
    task automatic wait_flag(input int sel);
        int n;
        n = 0;
        while ((sel == 0 ? rx_buf_valid : sel == 1 ? rx_stopped :
                sel == 2 ? tx_buf_valid : tx_stopped) !== 1'b1)
        begin
            @(negedge clk);
            n++;
            if (n > 300)
            begin
                error_cnt++;
                end_sim();
            end
        end
    endtask

    // One-cycle pulse: 0 rx poke, 1 tx poke, 2 close, 3 tx done
    task automatic pulse(input int sel);
        @(negedge clk);
        rx_poke = (sel == 0);
        tx_poke = (sel == 1);
        close_v = (sel == 2);
        done_v  = (sel == 3);
        @(negedge clk);
        {rx_poke, tx_poke, close_v, done_v} = 4'h0;
    endtask

    // Close held receive buffer, then wait for the given flag
    task automatic close_buf(input logic [24:0] c, input int nxt);
        close = c;
        pulse(2);
        wait_flag(nxt);
    endtask

    // Two-buffer frame, wrap, then stop on a consumed descriptor
    task automatic rx_ring_walk();
        pulse(0);
        wait_flag(0);
        check32("rx ptr 0", 32'h0000_2000, rx_buf_addr);
        close_buf({1'b0, 16'h0000, 8'hff}, 0);
        check32("rx wb 0", 32'h4488_0120, i_mem.mem[8'h40]);
        check32("rx ptr 1", 32'h0000_2010, rx_buf_addr);
        close_buf({1'b1, 16'h0040, 8'hfd}, 1);
        check32("rx wb 1", 32'h39b1_0040, i_mem.mem[8'h42]);
        check32("rx wrap", 32'h0000_0100, i_mem.last_rd);
    endtask

    // Handed back again; overrun frame, then stop at next slot
    task automatic rx_overrun();
        i_mem.mem[8'h40] = 32'hc488_0000;
        pulse(0);
        wait_flag(0);
        check32("rx restart", 32'h0000_2000, rx_buf_addr);
        close_buf({1'b1, 16'h07f0, 8'hfe}, 1);
        check32("rx ovr wb", 32'h4c8a_07f0, i_mem.mem[8'h40]);
        check32("rx next", 32'h0000_0108, i_mem.last_rd);
    endtask

    // Last transmit buffer with slow memory, wrap and stop
    task automatic tx_single();
        slow = 2'h2;
        pulse(1);
        wait_flag(2);
        check32("tx addr", 32'h0000_3004, tx_buf.addr);
        check32("tx len", 32'h0000_1220, {16'h0, tx_buf.len});
        check32("tx last", 32'h1, {31'h0, tx_buf.last});
        check32("tx app", 32'h1, 32'(tx_buf.append_checksum_flag));
        check32("tx bad", 32'h1, 32'(tx_buf.corrupt_checksum_flag));
        pulse(3);
        wait_flag(3);
        check32("tx wb", 32'h6e00_1234, i_mem.mem[8'h80]);
        check32("tx wrap", 32'h0000_0200, i_mem.last_rd);
    endtask

    // Disable reloads ring start; miss masked without accept-all
    task automatic rx_reload();
        enable = 1'b0;
        accept = 1'b0;
        i_mem.mem[8'h40] = 32'h8000_0000;
        @(negedge clk);
        enable = 1'b1;
        pulse(0);
        wait_flag(0);
        check32("rx reload", 32'h0000_2000, rx_buf_addr);
        close_buf({1'b1, 16'h0044, 8'ha0}, 1);
        check32("rx miss", 32'h0840_0044, i_mem.mem[8'h40]);
    endtask

    // Main sequence
    initial
    begin
        i_mem.mem[8'h40] = 32'hc488_0000;
        i_mem.mem[8'h41] = 32'h0000_2000;
        i_mem.mem[8'h42] = 32'hb000_0000;
        i_mem.mem[8'h43] = 32'h0000_2010;
        i_mem.mem[8'h80] = 32'hee00_1234;
        i_mem.mem[8'h81] = 32'h0000_3004;
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        enable = 1'b1;
        rx_ring_walk();
        rx_overrun();
        tx_single();
        rx_reload();
        end_sim();
    end
endmodule
`default_nettype wire
